/* File: verilog/rivp_consts.svh */
// rivp_consts.svh: numeric constants of the reset and vector placement block
// assumes: included by bare name wherever the numbers below are needed
`ifndef RIVP_CONSTS_SVH
`define RIVP_CONSTS_SVH

// ----------------------------------------------------------------------
// table shape
// ----------------------------------------------------------------------
`define RIVP_NUM_VECTORS   26
`define RIVP_NUM_IRQ       25
`define RIVP_ADDR_W        12
`define RIVP_OFS_W         5

// ----------------------------------------------------------------------
// default placement
// ----------------------------------------------------------------------
`define RIVP_RESET_ADDR    12'h000
`define RIVP_VEC_START     12'h001
`define RIVP_BOOT_ADDR_DEF 12'hc00

// ----------------------------------------------------------------------
// boot reset fuse encoding and reset values
// ----------------------------------------------------------------------
`define RIVP_FUSE_UNPROG   1'b1
`define RIVP_FUSE_PROG     1'b0
`define RIVP_FUSE_RST      1'b1
`define RIVP_SYNC_RST      3'h7

`endif

/* File: verilog/rivp_pkg.sv */
// rivp_pkg: types of the reset and vector placement block
// assumes: nothing beyond a SystemVerilog compiler
package rivp_pkg;

  // ----------------------------------------------------------------------
  // vector sources, each coded with its table offset
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    rivp_src_reset                 = 5'h00,
    rivp_src_external_request_zero = 5'h01,
    rivp_src_external_request_one  = 5'h02,
    rivp_src_pin_change_group_zero = 5'h03,
    rivp_src_pin_change_group_one  = 5'h04,
    rivp_src_pin_change_group_two  = 5'h05,
    rivp_src_watchdog_timeout      = 5'h06,
    rivp_src_tmr2_cmp_a            = 5'h07,
    rivp_src_tmr2_cmp_b            = 5'h08,
    rivp_src_tmr2_ovf              = 5'h09,
    rivp_src_tmr1_capture          = 5'h0a,
    rivp_src_tmr1_cmp_a            = 5'h0b,
    rivp_src_tmr1_cmp_b            = 5'h0c,
    rivp_src_tmr1_ovf              = 5'h0d,
    rivp_src_tmr0_cmp_a            = 5'h0e,
    rivp_src_tmr0_cmp_b            = 5'h0f,
    rivp_src_tmr0_ovf              = 5'h10,
    rivp_src_spi_transfer_complete = 5'h11,
    rivp_src_uart_rx_complete      = 5'h12,
    rivp_src_tx_data_empty         = 5'h13,
    rivp_src_uart_tx_complete      = 5'h14,
    rivp_src_converter_complete    = 5'h15,
    rivp_src_eeprom_ready          = 5'h16,
    rivp_src_analog_comparator     = 5'h17,
    rivp_src_two_wire_serial       = 5'h18,
    rivp_src_program_store_ready   = 5'h19
  } rivp_src_t;

endpackage : rivp_pkg

/* File: verilog/rivp_prio_enc.sv */
// rivp_prio_enc: lowest-index-first priority encoder
// assumes: requests are on the same clock as the user; purely combinational
`timescale 1ns/10ps
module rivp_prio_enc #(
  parameter int N  = 25,
  parameter int IW = 5
) (
  // request vector
  input  wire logic [N-1:0]  req_in,
  // result
  output logic               any_out,
  output logic [IW-1:0]      idx_out
);

  // ----------------------------------------------------------------------
  // one-hot winner by a carry chain
  // ----------------------------------------------------------------------
  logic [N:0]   seen;   // some lower bit already requested
  logic [N-1:0] win;    // one-hot winner

  assign seen[0] = 1'b0;

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_chain
      assign win[g]    = req_in[g] & ~seen[g];
      assign seen[g+1] = seen[g] | req_in[g];
    end
  endgenerate

  assign any_out = seen[N];

  // fold the one-hot winner into its index
  always_comb
  begin
    idx_out = '0;
    for (int i = 0; i < N; i++)
      if (win[i])
        idx_out = IW'(i);
  end

endmodule : rivp_prio_enc

/* File: verilog/rivp_vector_gen.sv */
// rivp_vector_gen: reset address and interrupt vector address generation
// assumes: requests and the vector select bit come from logic on clock_in;
// the boot reset fuse is a level from outside and is synchronised here
//
// Behaviour
// - 26 vectors; reset entry defaults to 0x000
// - externals 0x001/0x002, pin-change 0x003-0x005, watchdog 0x006
// - second 8-bit timer at 0x007-0x009
// - 16-bit timer at 0x00a-0x00d
// - first 8-bit timer at 0x00e-0x010
// - serial transfer 0x011, uart 0x012-0x014
// - converter, eeprom, comparator, two-wire, store 0x015-0x019
// - programmed fuse: reset at boot reset address
// - select bit set: vectors moved by boot start
// - reset by fuse only, table by select only
// - fuse 1 unprogrammed, 0 programmed
`include "rivp_consts.svh"
`timescale 1ns/10ps
module rivp_vector_gen #(
  parameter int                      ADDR_W    = `RIVP_ADDR_W,
  parameter int                      NUM_IRQ   = `RIVP_NUM_IRQ,
  parameter logic [`RIVP_ADDR_W-1:0] BOOT_ADDR = `RIVP_BOOT_ADDR_DEF
) (
  // clock and reset
  input  wire logic                 clock_in,
  input  wire logic                 rst_b_in,
  // configuration
  input  wire logic                 boot_reset_select_fuse_in,
  input  wire logic                 vector_select_bit_in,
  // peripheral requests, bit k is vector number k+2
  input  wire logic [NUM_IRQ-1:0]   irq_req_in,
  // towards the core
  output logic [ADDR_W-1:0]         reset_addr_out,
  output logic                      irq_pending_out,
  output logic [ADDR_W-1:0]         irq_vector_addr_out,
  output rivp_pkg::rivp_src_t       irq_source_out
);
  import rivp_pkg::*;

  // ----------------------------------------------------------------------
  // fuse synchroniser and filter
  // ----------------------------------------------------------------------
  logic [2:0] fuse_sync_q;   // three-stage synchroniser
  logic       fuse_q;        // accepted fuse level
  logic       fuse_d;
  wire        fuse_agree = (fuse_sync_q[1] == fuse_sync_q[2]);

  // take the new level only once stages two and three agree
  assign fuse_d = fuse_agree ? fuse_sync_q[2] : fuse_q;

  // synchroniser chain and filtered fuse register
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      fuse_sync_q <= `RIVP_SYNC_RST;
      fuse_q      <= `RIVP_FUSE_RST;
    end
    else
    begin
      fuse_sync_q <= {fuse_sync_q[1:0], boot_reset_select_fuse_in};
      fuse_q      <= fuse_d;
    end
  end

  // ----------------------------------------------------------------------
  // reset address selection
  // ----------------------------------------------------------------------
  logic [ADDR_W-1:0] reset_addr_d;

  // fuse alone picks the reset target
  assign reset_addr_d = (fuse_q == `RIVP_FUSE_UNPROG)
                      ? ADDR_W'(`RIVP_RESET_ADDR)
                      : BOOT_ADDR;

  // ----------------------------------------------------------------------
  // vector selection
  // ----------------------------------------------------------------------
  logic                  win_any;    // some request pending
  logic [4:0]            win_idx;    // lowest pending request bit
  logic [4:0]            win_ofs;    // table offset of the winner
  logic [ADDR_W-1:0]     table_base; // start of the table, the reset slot at offset 0
  logic [ADDR_W-1:0]     vec_addr_d;

  // lowest bit wins
  rivp_prio_enc #(
    .N  (NUM_IRQ),
    .IW (5)
  ) u_prio (
    .req_in  (irq_req_in),
    .any_out (win_any),
    .idx_out (win_idx)
  );

  // request bit k sits at table offset k+1
  assign win_ofs    = 5'(win_idx + 5'h01);
  // select bit alone moves the table base
  assign table_base = vector_select_bit_in ? BOOT_ADDR
                                           : ADDR_W'(0);
  assign vec_addr_d = ADDR_W'(table_base + {{(ADDR_W-5){1'b0}}, win_ofs});

  // registered answer to the core, refreshed every cycle
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      reset_addr_out      <= ADDR_W'(`RIVP_RESET_ADDR);
      irq_pending_out     <= 1'b0;
      irq_vector_addr_out <= ADDR_W'(`RIVP_VEC_START);
      irq_source_out      <= rivp_src_reset;
    end
    else
    begin
      reset_addr_out      <= reset_addr_d;
      irq_pending_out     <= win_any;
      irq_vector_addr_out <= vec_addr_d;
      irq_source_out      <= win_any ? rivp_src_t'(win_ofs)
                                     : rivp_src_reset;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  property p_rst_default;
    fuse_q == `RIVP_FUSE_UNPROG |=> reset_addr_out == `RIVP_RESET_ADDR;
  endproperty
  a_rst_default: assert property (p_rst_default)
    else $error("reset address not zero with fuse unprogrammed");

  property p_ext_zero;
    irq_req_in == NUM_IRQ'(1)
      |=> irq_source_out == rivp_src_external_request_zero
          && irq_pending_out;
  endproperty
  a_ext_zero: assert property (p_ext_zero)
    else $error("first external request not at offset 1");

  property p_watchdog;
    irq_req_in == (NUM_IRQ'(1) << 5) && !vector_select_bit_in
      |=> irq_vector_addr_out == 12'h006;
  endproperty
  a_watchdog: assert property (p_watchdog)
    else $error("watchdog vector not at 0x006");

  property p_tmr2;
    irq_req_in == (NUM_IRQ'(1) << 8) && !vector_select_bit_in
      |=> irq_vector_addr_out == 12'h009;
  endproperty
  a_tmr2: assert property (p_tmr2)
    else $error("timer two overflow not at 0x009");

  property p_tmr1;
    irq_req_in == (NUM_IRQ'(1) << 9)
      |=> irq_source_out == rivp_src_tmr1_capture;
  endproperty
  a_tmr1: assert property (p_tmr1)
    else $error("timer one capture not at 0x00a");

  property p_tmr0;
    irq_req_in == (NUM_IRQ'(1) << 15)
      |=> irq_source_out == rivp_src_tmr0_ovf;
  endproperty
  a_tmr0: assert property (p_tmr0)
    else $error("timer zero overflow not at 0x010");

  property p_serial;
    irq_req_in == (NUM_IRQ'(1) << 18)
      |=> irq_source_out == rivp_src_tx_data_empty;
  endproperty
  a_serial: assert property (p_serial)
    else $error("transmit data empty not at 0x013");

  property p_store;
    irq_req_in == (NUM_IRQ'(1) << 24) && !vector_select_bit_in
      |=> irq_vector_addr_out == 12'h019;
  endproperty
  a_store: assert property (p_store)
    else $error("program store ready not at 0x019");

  property p_boot_reset;
    fuse_q == `RIVP_FUSE_PROG |=> reset_addr_out == BOOT_ADDR;
  endproperty
  a_boot_reset: assert property (p_boot_reset)
    else $error("reset address not boot address with fuse programmed");

  property p_moved;
    irq_req_in == NUM_IRQ'(1) && vector_select_bit_in
      |=> irq_vector_addr_out == ADDR_W'(BOOT_ADDR + 12'h001);
  endproperty
  a_moved: assert property (p_moved)
    else $error("moved table not offset by boot start");

  property p_indep;
    $stable(fuse_q) && $changed(vector_select_bit_in)
      |=> $stable(reset_addr_out);
  endproperty
  a_indep: assert property (p_indep)
    else $error("select bit disturbed the reset address");

  property p_fuse_read;
    (boot_reset_select_fuse_in == `RIVP_FUSE_PROG) [*5]
      |=> ##1 reset_addr_out == BOOT_ADDR;
  endproperty
  a_fuse_read: assert property (p_fuse_read)
    else $error("held programmed fuse not taken");

  property p_prio;
    irq_req_in[3] && irq_req_in[10] && irq_req_in[2:0] == 3'h0
      |=> irq_source_out == rivp_src_pin_change_group_one;
  endproperty
  a_prio: assert property (p_prio)
    else $error("lower vector number did not win");

  c_boot_fuse: cover property (fuse_q == `RIVP_FUSE_PROG);
  c_moved:     cover property (irq_pending_out && vector_select_bit_in);
  c_multi:     cover property ($countones(irq_req_in) > 1);

endmodule : rivp_vector_gen

/* File: testbench/rivp_core_model.sv */
// rivp_core_model: core side that takes dispatched vector addresses
// assumes: samples the block outputs on the rising edge of clock_in
`timescale 1ns/10ps
module rivp_core_model (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  // from the vector block
  input  wire logic        pending_in,
  input  wire logic [11:0] vector_in,
  // fetch record
  output logic [11:0]      fetch_addr_out,
  output logic [11:0]      fetch_count_out
);
  // ----------------------------------------------------------------------
  // fetch: a vector slot is read only while a request is pending
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      fetch_addr_out  <= 12'h000;
      fetch_count_out <= 12'h000;
    end
    else if (pending_in)
    begin
      fetch_addr_out  <= vector_in;
      fetch_count_out <= fetch_count_out + 12'h001;
    end
  end
endmodule : rivp_core_model

/* File: testbench/test_rivp_vector_gen.sv */
// test_rivp_vector_gen: self-checking bench of the vector block
// assumes: design files and rivp_core_model compiled before this file
`include "rivp_consts.svh"
`timescale 1ns/10ps
module test_rivp_vector_gen;
  import rivp_pkg::*;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  localparam logic [11:0] BOOT = 12'h800; // boot section start under test
  logic        clock_in;
  logic        rst_b_in;
  logic        fuse;       // boot reset fuse level
  logic        vsel;       // vector select bit
  logic [24:0] req;        // peripheral requests
  logic [11:0] rst_addr;
  logic [11:0] vec_addr;
  logic [11:0] f_addr;
  logic [11:0] f_cnt;
  logic        pend;
  rivp_src_t   src;
  int          fail_count = 0;
  int          tests_run  = 0;

  rivp_vector_gen #(.BOOT_ADDR(BOOT)) uut (
    .clock_in                  (clock_in),
    .rst_b_in                  (rst_b_in),
    .boot_reset_select_fuse_in (fuse),
    .vector_select_bit_in      (vsel),
    .irq_req_in                (req),
    .reset_addr_out            (rst_addr),
    .irq_pending_out           (pend),
    .irq_vector_addr_out       (vec_addr),
    .irq_source_out            (src)
  );
  rivp_core_model core (
    .clock_in        (clock_in),
    .rst_b_in        (rst_b_in),
    .pending_in      (pend),
    .vector_in       (vec_addr),
    .fetch_addr_out  (f_addr),
    .fetch_count_out (f_cnt)
  );

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // apply requests at a falling edge, look after one rising edge
  task automatic step(input logic [24:0] r);
    req = r;
    @(posedge clock_in);
    @(negedge clock_in);
  endtask : step

  task automatic summarize;
    $display("checks %0d errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    check(rst_addr, 12'h000);
    check({11'h000, pend}, 12'h000);
    check(vec_addr, 12'h001);
  endtask : t_reset

  // every source alone, table at its default or moved place
  task automatic t_table(input logic sel);
    vsel = sel;
    for (int k = 0; k < 25; k++)
    begin
      step(25'h1 << k);
      check({11'h000, pend}, 12'h001);
      check(vec_addr, (sel ? BOOT : 12'h000) + 12'(k + 1));
      check({7'h00, src}, 12'(k + 1));
      // the core takes the registered address one edge later
      step(25'h1 << k);
      check(f_addr, (sel ? BOOT : 12'h000) + 12'(k + 1));
    end
  endtask : t_table

  // programmed fuse held over reset: zero first, boot once filtered
  task automatic t_rst_boot;
    step(25'h0);
    check(rst_addr, 12'h000);
    repeat (6) step(25'h0);
    check(rst_addr, BOOT);
  endtask : t_rst_boot

  // lowest pending number wins, then quiet: no fetch happens
  task automatic t_prio;
    logic [11:0] cnt;
    vsel = 1'b0;
    for (int k = 0; k < 25; k++)
    begin
      step(25'h1ffffff << k);
      check({7'h00, src}, 12'(k + 1));
    end
    step(25'h0);
    cnt = f_cnt;
    step(25'h0);
    check(f_cnt, cnt);
    check({7'h00, src}, 12'h000);
  endtask : t_prio

  // fuse moves reset only; select moves table only
  task automatic t_fuse;
    fuse = 1'b0;
    vsel = 1'b0;
    repeat (8) step(25'h0);
    check(rst_addr, BOOT);
    step(25'h1);
    check(vec_addr, 12'h001);
    vsel = 1'b1;
    step(25'h1);
    check(rst_addr, BOOT);
    check(vec_addr, BOOT + 12'h001);
    fuse = 1'b1;
    repeat (8) step(25'h0);
    check(rst_addr, 12'h000);
  endtask : t_fuse

  // ----------------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  initial
  begin
    #(3000 * 25);
    fail_count++;
    summarize();
  end

  initial
  begin
    rst_b_in = 1'b0;
    fuse     = 1'b1;
    vsel     = 1'b0;
    req      = 25'h0;
    repeat (6) @(posedge clock_in);
    @(negedge clock_in);
    rst_b_in = 1'b1;
    t_reset();
    t_table(1'b0);
    t_table(1'b1);
    t_prio();
    t_fuse();
    fuse     = 1'b0;
    rst_b_in = 1'b0;
    repeat (6) step(25'h0);
    rst_b_in = 1'b1;
    t_reset();
    t_rst_boot();
    summarize();
  end
endmodule : test_rivp_vector_gen
